// ### rtl/fpm_map.svh
// Constants for the front panel menu controller.
`ifndef FPM_MAP_SVH
`define FPM_MAP_SVH
`define FPM_CLK_HZ     25000000
`define FPM_BAUD       9600
`define FPM_BAUD_DIV   ((`FPM_CLK_HZ + `FPM_BAUD / 2) / `FPM_BAUD)
`define FPM_FRAME_BITS 4'hA
`define FPM_IDLE_S     30
`define FPM_PHASE_MS   1000
`define FPM_REPLY      8'h3E
`define FPM_GAIN_MAX   18'sh0003C
`define FPM_FREQ_MIN   18'sh062A2
`define FPM_FREQ_MAX   18'sh06B6C
`define FPM_OFS_MAX    18'sh007D0
`define FPM_ADDR_MAX   18'sh0001F
`define FPM_REF_LAST   2'h2
`define FPM_STEP_1000  16'h03E8
`define FPM_STEP_100   16'h0064
`define FPM_STEP_10    16'h000A
`define FPM_STEP_1     16'h0001
`define FPM_STEP_10DB  16'h0014
`define FPM_STEP_1DB   16'h0002
`define FPM_RST_FREQ   15'h67B6
`define FPM_RST_GAIN   6'h14
`endif

// ### rtl/fpm_pkg.sv
// Types shared by the front panel menu controller.
package fpm_pkg;
    typedef enum logic [2:0] {
        ST_LAMP = 3'b000,
        ST_VER  = 3'b001,
        ST_NORM = 3'b010,
        ST_MENU = 3'b011,
        ST_SAVE = 3'b100
    } fpm_state_e;
    typedef enum logic [2:0] {
        MN_FREQ = 3'b000,
        MN_GAIN = 3'b001,
        MN_MUTE = 3'b010,
        MN_REF  = 3'b011,
        MN_OFS  = 3'b100,
        MN_REM  = 3'b101,
        MN_IF   = 3'b110,
        MN_ADDR = 3'b111
    } fpm_menu_e;
    typedef struct packed {
        logic        [14:0] freq;
        logic        [5:0]  gain;
        logic               mute;
        logic        [1:0]  ref_mode;
        logic signed [11:0] ofs;
        logic               remote;
        logic               iface;
        logic        [4:0]  addr;
    } fpm_cfg_s;
endpackage : fpm_pkg

// ### rtl/fpm_sw_edge.sv
// Switch press detector: one pulse per rising switch level.
`timescale 1ns/1ns
module fpm_sw_edge #(
    parameter int N = 5
) (
    input  wire logic         core_clk_i, // Clock
    input  wire logic         resetn_i,   // Async reset, active low
    input  wire logic [N-1:0] sw_i,       // Switch levels
    output logic      [N-1:0] press_o     // Press pulses
);
    logic [N-1:0] prev_r;
    logic [N-1:0] prev_nxt;
    logic [N-1:0] press_nxt;

    // A switch held through reset must not count as a press.
    always_comb
    begin
        prev_nxt  = sw_i;
        press_nxt = sw_i & ~prev_r;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            prev_r  <= '1;
            press_o <= '0;
        end
        else
        begin
            prev_r  <= prev_nxt;
            press_o <= press_nxt;
        end
    end
endmodule : fpm_sw_edge

// ### rtl/fpm_uart_tx.sv
// Serial character transmitter, one start, eight data, one stop bit.
`timescale 1ns/1ns
`include "fpm_map.svh"
module fpm_uart_tx #(
    parameter int unsigned DIV = `FPM_BAUD_DIV
) (
    input  wire logic       core_clk_i, // Clock
    input  wire logic       resetn_i,   // Async reset, active low
    input  wire logic       start_i,    // Send request pulse
    input  wire logic [7:0] data_i,     // Character
    output logic            txd_o,      // Serial line, idle high
    output logic            busy_o      // Character in flight
);
    localparam int CW = $clog2(DIV);
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic [3:0]    bit_r, bit_nxt;
    logic [9:0]    sh_r, sh_nxt;
    logic          txd_nxt, busy_nxt;

    always_comb
    begin
        cnt_nxt  = cnt_r;
        bit_nxt  = bit_r;
        sh_nxt   = sh_r;
        busy_nxt = busy_o;
        txd_nxt  = txd_o;
        if (!busy_o)
        begin
            if (start_i)
            begin
                sh_nxt   = {1'b1, data_i, 1'b0};
                busy_nxt = 1'b1;
                cnt_nxt  = '0;
                bit_nxt  = '0;
                txd_nxt  = 1'b0;
            end
        end
        else if (cnt_r == CW'(DIV - 1))
        begin
            cnt_nxt = '0;
            bit_nxt = bit_r + 4'h1;
            sh_nxt  = {1'b1, sh_r[9:1]};
            if (bit_r == `FPM_FRAME_BITS - 4'h1)
            begin
                busy_nxt = 1'b0;
                txd_nxt  = 1'b1;
            end
            else
                txd_nxt = sh_r[1];
        end
        else
            cnt_nxt = cnt_r + CW'(1);
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            cnt_r  <= '0;
            bit_r  <= '0;
            sh_r   <= '1;
            busy_o <= 1'b0;
            txd_o  <= 1'b1;
        end
        else
        begin
            cnt_r  <= cnt_nxt;
            bit_r  <= bit_nxt;
            sh_r   <= sh_nxt;
            busy_o <= busy_nxt;
            txd_o  <= txd_nxt;
        end
    end
endmodule : fpm_uart_tx

// ### rtl/fpm_ctrl.sv
// Front panel menu controller: switches, staged edits, save, alarm.
`timescale 1ns/1ns
`include "fpm_map.svh"
// Overview of operation
// - Serial port runs 9600 baud, one start, eight data, no parity, one stop.
// - Local control comes only from three switches; display and lamps report.
// - Return item in any menu, or leaving the last menu, opens save menu.
// - Sessions start on execute; edits other than gain apply only after execute in save menu.
// - About 30 s without switch activity drops the session and display.
// - Saved settings sit in retained storage and reload at power-up.
// - Power-up shows all segments, then version, then frequency and gain.
// - Horizontal press moves the cursor one place left or right, stopping at either end.
// - Vertical press raises or lowers the numeric digit under the cursor.
// - Vertical press toggles on/off settings whichever way it moves.
// - Gain follows edits live but is stored only on save yes.
// - Gain steps are 0.5, 1 or 10 dB by cursor digit.
// - Execute off the return item advances to the next menu item; in the last menu it opens save menu.
// - Save yes commits all staged values; no restores all, live gain too.
// - Alarm rises whenever any oscillator loop reports loss of lock.
// - Remote lamp follows the selected remote mode one clock later.
// - Gain is limited to 30 dB in half-decibel units.
// - Alarm drives a changeover relay to the rear connector.
// - Frames use brace delimiters; device answers with > each command executed while no reply is on the line.
// - Multi-drop frames carry unit address 00 to 31; point-to-point omits it.
module fpm_ctrl
    import fpm_pkg::*;
#(
    parameter int          NPLL     = 2,
    parameter int          TW       = 30,
    parameter int unsigned PH_CYC   = (`FPM_CLK_HZ / 1000) * `FPM_PHASE_MS,
    parameter int unsigned IDLE_CYC = `FPM_IDLE_S * `FPM_CLK_HZ
) (
    input  wire logic            core_clk_i,    // Clock, 25 MHz
    input  wire logic            resetn_i,      // Async reset, active low
    input  wire logic            sw_exec_i,     // Menu/execute switch
    input  wire logic            sw_left_i,     // Horizontal switch, left
    input  wire logic            sw_right_i,    // Horizontal switch, right
    input  wire logic            sw_up_i,       // Vertical switch, up
    input  wire logic            sw_down_i,     // Vertical switch, down
    input  wire logic [NPLL-1:0] pll_unlock_i,  // Loop lost lock flags
    input  wire logic            cmd_done_i,    // Remote command executed
    input  wire fpm_cfg_s        nv_data_i,     // Retained settings
    output fpm_cfg_s             nv_data_o,     // Settings to retain
    output logic                 nv_wr_o,       // Retain strobe
    output logic      [2:0]      screen_o,      // Display screen
    output logic      [2:0]      menu_o,        // Menu shown
    output logic      [2:0]      cursor_o,      // Cursor place
    output fpm_cfg_s             edit_o,        // Staged values shown
    output logic      [14:0]     freq_o,        // Frequency, MHz
    output logic      [5:0]      gain_o,        // Live gain, 0.5 dB
    output logic                 mute_o,        // Output muted
    output logic      [1:0]      ref_mode_o,    // Reference mode
    output logic      [11:0]     ref_ofs_o,     // Reference offset
    output logic                 remote_o,      // Remote mode
    output logic                 iface_o,       // 1: multi-drop
    output logic      [4:0]      addr_o,        // Unit address
    output logic                 txd_o,         // Serial transmit
    output logic                 power_lamp_o,  // Power lamp
    output logic                 remote_lamp_o, // Remote lamp
    output logic                 fault_lamp_o,  // Alarm lamp
    output logic                 relay_o        // Alarm relay coil
);
    // ---------------------------------------------------------------
    // Switch presses and helpers
    // ---------------------------------------------------------------
    logic [4:0] press;
    logic exec_p, lf_p, rt_p, up_p, dn_p, any_p;

    fpm_sw_edge #(.N(5)) u_edge (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .sw_i       ({sw_exec_i, sw_left_i, sw_right_i,
                      sw_up_i, sw_down_i}),
        .press_o    (press)
    );
    assign {exec_p, lf_p, rt_p, up_p, dn_p} = press;
    assign any_p = |press;

    // Cursor places per menu, the return item last.
    function automatic logic [2:0] npos(input logic [2:0] m);
        case (m)
            MN_FREQ, MN_OFS: npos = 3'h5;
            MN_GAIN:         npos = 3'h4;
            MN_ADDR:         npos = 3'h3;
            default:         npos = 3'h2;
        endcase
    endfunction : npos

    function automatic logic [15:0] step(input logic [2:0] m,
                                         input logic [2:0] c);
        logic [15:0] s;
        s = `FPM_STEP_1;
        case (m)
            MN_FREQ, MN_OFS:
                case (c)
                    3'h0:    s = `FPM_STEP_1000;
                    3'h1:    s = `FPM_STEP_100;
                    3'h2:    s = `FPM_STEP_10;
                    default: s = `FPM_STEP_1;
                endcase
            MN_GAIN:
                case (c)
                    3'h0:    s = `FPM_STEP_10DB;
                    3'h1:    s = `FPM_STEP_1DB;
                    default: s = `FPM_STEP_1;
                endcase
            MN_ADDR: s = (c == 3'h0) ? `FPM_STEP_10 : `FPM_STEP_1;
            default: s = `FPM_STEP_1;
        endcase
        step = s;
    endfunction : step

    // Step up or down and clamp into range.
    function automatic logic signed [17:0] adj(
        input logic signed [17:0] v,
        input logic        [15:0] s,
        input logic               up,
        input logic signed [17:0] lo,
        input logic signed [17:0] hi);
        logic signed [17:0] r;
        r = up ? v + $signed({2'b00, s}) : v - $signed({2'b00, s});
        if (r > hi)
            r = hi;
        if (r < lo)
            r = lo;
        adj = r;
    endfunction : adj

    // ---------------------------------------------------------------
    // Menu state machine
    // ---------------------------------------------------------------
    fpm_state_e    st_r, st_nxt;
    logic [2:0]    menu_r, menu_nxt;
    logic [2:0]    cur_r, cur_nxt;
    logic [TW-1:0] tmr_r, tmr_nxt;
    fpm_cfg_s      act_r, act_nxt;
    fpm_cfg_s      ed_r, ed_nxt;
    logic [5:0]    gain_r, gain_nxt;
    logic          ld_r, wr_r, wr_nxt;
    logic [15:0]   stp;
    logic [2:0]    rpos;
    logic          sess;

    assign sess = (st_r == ST_MENU) || (st_r == ST_SAVE);

    always_comb
    begin
        st_nxt   = st_r;
        menu_nxt = menu_r;
        cur_nxt  = cur_r;
        tmr_nxt  = tmr_r;
        act_nxt  = act_r;
        ed_nxt   = ed_r;
        wr_nxt   = 1'b0;
        stp      = step(menu_r, cur_r);
        rpos     = npos(menu_r) - 3'h1;
        case (st_r)
            ST_LAMP, ST_VER:
            begin
                if (!ld_r)
                    act_nxt = nv_data_i;
                if (tmr_r == TW'(PH_CYC - 1))
                begin
                    tmr_nxt = '0;
                    st_nxt  = (st_r == ST_LAMP) ? ST_VER : ST_NORM;
                end
                else
                    tmr_nxt = tmr_r + TW'(1);
            end
            ST_NORM:
            begin
                tmr_nxt = '0;
                if (exec_p)
                begin
                    st_nxt   = ST_MENU;
                    menu_nxt = MN_FREQ;
                    cur_nxt  = '0;
                    ed_nxt   = act_r;
                end
            end
            ST_MENU, ST_SAVE:
            begin
                tmr_nxt = any_p ? '0 : tmr_r + TW'(1);
                if (st_r == ST_SAVE && exec_p)
                begin
                    st_nxt = ST_NORM;
                    if (cur_r == 3'h0)
                    begin
                        act_nxt = ed_r;
                        wr_nxt  = 1'b1;
                    end
                    else
                        ed_nxt = act_r;
                end
                else if (st_r == ST_SAVE)
                begin
                    if (rt_p)
                        cur_nxt = 3'h1;
                    else if (lf_p)
                        cur_nxt = 3'h0;
                end
                else if (exec_p)
                begin
                    cur_nxt = '0;
                    if (cur_r == rpos || menu_r == MN_ADDR)
                        st_nxt = ST_SAVE;
                    else
                        menu_nxt = menu_r + 3'h1;
                end
                else if (rt_p && cur_r < rpos)
                    cur_nxt = cur_r + 3'h1;
                else if (lf_p && cur_r != 3'h0)
                    cur_nxt = cur_r - 3'h1;
                else if ((up_p || dn_p) && cur_r != rpos)
                begin
                    case (menu_r)
                        MN_FREQ: ed_nxt.freq = 15'(adj(
                            $signed({3'b000, ed_r.freq}), stp, up_p,
                            `FPM_FREQ_MIN, `FPM_FREQ_MAX));
                        MN_GAIN: ed_nxt.gain = 6'(adj(
                            $signed({12'h000, ed_r.gain}), stp, up_p,
                            18'sh00000, `FPM_GAIN_MAX));
                        MN_OFS: ed_nxt.ofs = 12'(adj(
                            18'(ed_r.ofs), stp, up_p,
                            -`FPM_OFS_MAX, `FPM_OFS_MAX));
                        MN_ADDR: ed_nxt.addr = 5'(adj(
                            $signed({13'h0000, ed_r.addr}), stp, up_p,
                            18'sh00000, `FPM_ADDR_MAX));
                        MN_MUTE: ed_nxt.mute = ~ed_r.mute;
                        MN_REM: ed_nxt.remote = ~ed_r.remote;
                        MN_IF: ed_nxt.iface = ~ed_r.iface;
                        MN_REF: ed_nxt.ref_mode =
                            (ed_r.ref_mode == `FPM_REF_LAST) ? 2'h0
                            : ed_r.ref_mode + 2'h1;
                        default: ed_nxt = ed_r;
                    endcase
                end
                // The press that lands on the last idle cycle keeps the session.
                if (!exec_p && !any_p && tmr_r == TW'(IDLE_CYC - 1))
                begin
                    st_nxt  = ST_NORM;
                    ed_nxt  = act_r;
                    tmr_nxt = '0;
                end
            end
            default: st_nxt = ST_LAMP;
        endcase
        // Gain is heard live while a session runs, the saved value otherwise.
        gain_nxt = (st_nxt == ST_MENU || st_nxt == ST_SAVE) ?
                   ed_nxt.gain : act_nxt.gain;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            st_r   <= ST_LAMP;
            menu_r <= MN_FREQ;
            cur_r  <= '0;
            tmr_r  <= '0;
            act_r  <= '{freq: `FPM_RST_FREQ, gain: `FPM_RST_GAIN,
                        default: '0};
            ed_r   <= '{freq: `FPM_RST_FREQ, gain: `FPM_RST_GAIN,
                        default: '0};
            gain_r <= `FPM_RST_GAIN;
            ld_r   <= 1'b0;
            wr_r   <= 1'b0;
        end
        else
        begin
            st_r   <= st_nxt;
            menu_r <= menu_nxt;
            cur_r  <= cur_nxt;
            tmr_r  <= tmr_nxt;
            act_r  <= act_nxt;
            ed_r   <= ed_nxt;
            gain_r <= gain_nxt;
            ld_r   <= 1'b1;
            wr_r   <= wr_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Lamps, alarm relay and remote reply
    // ---------------------------------------------------------------
    logic alarm_r, alarm_nxt, rlamp_r, rlamp_nxt, plamp_r;
    logic reply_go, tx_busy;

    always_comb
    begin
        alarm_nxt = |pll_unlock_i;
        rlamp_nxt = act_r.remote;
    end

    always_ff @(posedge core_clk_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            alarm_r <= 1'b0;
            rlamp_r <= 1'b0;
            plamp_r <= 1'b0;
        end
        else
        begin
            alarm_r <= alarm_nxt;
            rlamp_r <= rlamp_nxt;
            plamp_r <= 1'b1;
        end
    end

    // A reply asked for while one is still on the line is dropped.
    assign reply_go = cmd_done_i && !tx_busy;

    fpm_uart_tx #(.DIV(`FPM_BAUD_DIV)) u_tx (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .start_i    (reply_go),
        .data_i     (`FPM_REPLY),
        .txd_o      (txd_o),
        .busy_o     (tx_busy)
    );

    assign nv_data_o     = act_r;
    assign nv_wr_o       = wr_r;
    assign screen_o      = st_r;
    assign menu_o        = menu_r;
    assign cursor_o      = cur_r;
    assign edit_o        = ed_r;
    assign freq_o        = act_r.freq;
    assign gain_o        = gain_r;
    assign mute_o        = act_r.mute;
    assign ref_mode_o    = act_r.ref_mode;
    assign ref_ofs_o     = act_r.ofs;
    assign remote_o      = act_r.remote;
    assign iface_o       = act_r.iface;
    assign addr_o        = act_r.addr;
    assign power_lamp_o  = plamp_r;
    assign remote_lamp_o = rlamp_r;
    assign fault_lamp_o  = alarm_r;
    assign relay_o       = alarm_r;

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);

    sequence save_yes_s;
        st_r == ST_SAVE && exec_p && cur_r == 3'h0;
    endsequence
    sequence save_no_s;
        st_r == ST_SAVE && exec_p && cur_r != 3'h0;
    endsequence

    power_order_a: assert property ($changed(st_r) && st_r == ST_VER
        |-> $past(st_r) == ST_LAMP)
        else $error("version screen not after lamp test");
    sess_start_a: assert property ($past(st_r) == ST_NORM && sess
        |-> $past(exec_p))
        else $error("session opened without execute");
    commit_yes_a: assert property (save_yes_s
        |=> act_r == $past(ed_r) && nv_wr_o ##1 !nv_wr_o)
        else $error("save yes did not commit once");
    restore_no_a: assert property (save_no_s
        |=> act_r == $past(act_r) && gain_o == act_r.gain)
        else $error("save no did not restore");
    idle_drop_a: assert property (sess && !any_p
        && tmr_r == TW'(IDLE_CYC - 1)
        |=> st_r == ST_NORM && act_r == $past(act_r))
        else $error("idle session not dropped");
    idle_rst_a: assert property (sess && any_p
        |=> tmr_r == '0)
        else $error("idle timer not restarted");
    return_item_a: assert property (st_r == ST_MENU && exec_p
        && cur_r == npos(menu_r) - 3'h1 |=> st_r == ST_SAVE)
        else $error("return item did not open save menu");
    toggle_a: assert property (st_r == ST_MENU && menu_r == MN_REM
        && cur_r == 3'h0 && !exec_p && !lf_p && !rt_p && (up_p || dn_p)
        |=> ed_r.remote != $past(ed_r.remote))
        else $error("remote setting did not toggle");
    gain_cap_a: assert property (gain_o <= 6'(`FPM_GAIN_MAX))
        else $error("gain above limit");
    alarm_relay_a: assert property (|pll_unlock_i
        |=> relay_o && fault_lamp_o)
        else $error("unlock did not raise alarm");
    remote_lamp_a: assert property (remote_lamp_o
        == $past(act_r.remote))
        else $error("remote lamp disagrees with mode");
endmodule : fpm_ctrl

// ### bench/fpm_operator.sv
// Operator model that works the three front panel switches.
`timescale 1ns/1ns
module fpm_operator (
    input  wire logic       core_clk_i, // Clock
    output logic      [4:0] sw_o        // Bit 0 execute, then left, right, up, down
);
    // Switches rest low so that every press is a clean rising level.
    initial sw_o = 5'h00;
    task automatic press(input int k);
        @(posedge core_clk_i);
        sw_o[k] <= 1'b1;
        repeat (3) @(posedge core_clk_i);
        sw_o[k] <= 1'b0;
        @(posedge core_clk_i);
    endtask : press
endmodule : fpm_operator

// ### bench/testbench.sv
// Self-checking bench for the front panel menu controller.
`timescale 1ns/1ns
module testbench;
    import fpm_pkg::*;
    logic       core_clk_i, resetn_i, cmd_done_i, nv_wr_o, txd_o;
    logic       power_lamp_o, remote_lamp_o, fault_lamp_o, relay_o, remote_o, mute_o, iface_o;
    logic [1:0] pll_unlock_i, ref_mode_o;
    logic [4:0] sw, addr_o;
    logic [2:0] screen_o, menu_o, cursor_o;
    logic [14:0] freq_o;
    logic [11:0] ref_ofs_o;
    logic [5:0] gain_o;
    fpm_cfg_s   edit_o, nv_data_o;
    fpm_cfg_s   nv_data_i = '{freq: 15'h67B6, gain: 6'h10, ref_mode: 2'h2, addr: 5'h03, default: '0};
    int         err_count, checks, wr_cnt;
    fpm_operator op (.core_clk_i(core_clk_i), .sw_o(sw));
    fpm_ctrl #(.PH_CYC(8), .IDLE_CYC(50)) dut (
        .core_clk_i(core_clk_i), .resetn_i(resetn_i), .sw_exec_i(sw[0]),
        .sw_left_i(sw[1]), .sw_right_i(sw[2]), .sw_up_i(sw[3]), .sw_down_i(sw[4]),
        .pll_unlock_i(pll_unlock_i), .cmd_done_i(cmd_done_i), .nv_data_i(nv_data_i),
        .nv_data_o(nv_data_o), .nv_wr_o(nv_wr_o), .screen_o(screen_o), .menu_o(menu_o),
        .cursor_o(cursor_o), .edit_o(edit_o), .freq_o(freq_o), .gain_o(gain_o),
        .mute_o(mute_o), .ref_mode_o(ref_mode_o), .ref_ofs_o(ref_ofs_o), .remote_o(remote_o),
        .iface_o(iface_o), .addr_o(addr_o), .txd_o(txd_o), .power_lamp_o(power_lamp_o),
        .remote_lamp_o(remote_lamp_o), .fault_lamp_o(fault_lamp_o), .relay_o(relay_o));
    initial
    begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    // Retained storage: a write strobe keeps the settings for the next power-up.
    always @(posedge core_clk_i)
        if (nv_wr_o === 1'b1)
        begin
            wr_cnt++;
            nv_data_i <= nv_data_o;
        end
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict
    task automatic t_power_up();
        repeat (2) @(posedge core_clk_i);
        chk("screen", screen_o, 32'h0);
        chk("freq", freq_o, 32'h67B6);
        chk("power_lamp", power_lamp_o, 32'h1);
        chk("ref_mode", ref_mode_o, 32'h2);
        chk("addr", addr_o, 32'h3);
        repeat (11) @(posedge core_clk_i);
        chk("screen", screen_o, 32'h1);
        repeat (9) @(posedge core_clk_i);
        chk("screen", screen_o, 32'h2);
        chk("gain", gain_o, 32'h10);
        $display("power up done");
    endtask : t_power_up
    task automatic t_gain_discard();
        op.press(0);
        chk("menu", {screen_o, menu_o, cursor_o}, 32'hC0);
        op.press(0);
        chk("menu", menu_o, 32'h1);
        op.press(3);
        chk("gain", gain_o, 32'h24);
        op.press(2);
        chk("cursor", cursor_o, 32'h1);
        op.press(3);
        chk("gain", gain_o, 32'h26);
        op.press(2);
        op.press(4);
        chk("gain", gain_o, 32'h25);
        repeat (2) op.press(1);
        chk("cursor", cursor_o, 32'h0);
        repeat (2) op.press(3);
        chk("gain", gain_o, 32'h3C);
        repeat (3) op.press(2);
        chk("cursor", cursor_o, 32'h3);
        op.press(0);
        chk("save", {screen_o, cursor_o}, 32'h20);
        op.press(2);
        op.press(0);
        chk("screen", screen_o, 32'h2);
        chk("gain", gain_o, 32'h10);
        chk("writes", wr_cnt, 32'h0);
        $display("gain discard done");
    endtask : t_gain_discard
    task automatic t_remote_save();
        repeat (6) op.press(0);
        chk("menu", menu_o, 32'h5);
        op.press(3);
        chk("remote", edit_o.remote, 32'h1);
        op.press(4);
        chk("remote", edit_o.remote, 32'h0);
        op.press(3);
        chk("remote", remote_o, 32'h0);
        repeat (3) op.press(0);
        chk("screen", screen_o, 32'h4);
        op.press(0);
        repeat (2) @(posedge core_clk_i);
        chk("writes", wr_cnt, 32'h1);
        chk("remote", remote_o, 32'h1);
        chk("remote_lamp", remote_lamp_o, 32'h1);
        $display("remote save done");
    endtask : t_remote_save
    task automatic t_idle();
        op.press(0);
        op.press(3);
        chk("edit freq", edit_o.freq, 32'h6B6C);
        repeat (56) @(posedge core_clk_i);
        chk("screen", screen_o, 32'h2);
        chk("freq", freq_o, 32'h67B6);
        $display("idle timeout done");
    endtask : t_idle
    task automatic t_alarm();
        pll_unlock_i <= 2'h2;
        repeat (3) @(posedge core_clk_i);
        chk("alarm", {fault_lamp_o, relay_o}, 32'h3);
        pll_unlock_i <= 2'h0;
        repeat (3) @(posedge core_clk_i);
        chk("alarm", {fault_lamp_o, relay_o}, 32'h0);
        $display("alarm done");
    endtask : t_alarm
    task automatic t_edit_save();
        repeat (3) op.press(0);
        op.press(3);
        op.press(0);
        op.press(4);
        op.press(0);
        op.press(4);
        repeat (2) op.press(0);
        op.press(3);
        op.press(0);
        repeat (3) op.press(3);
        repeat (2) op.press(0);
        repeat (2) @(posedge core_clk_i);
        chk("mute", mute_o, 32'h1);
        chk("ref_mode", ref_mode_o, 32'h0);
        chk("ofs", ref_ofs_o, 32'hC18);
        chk("iface", iface_o, 32'h1);
        chk("addr", addr_o, 32'h1F);
        chk("writes", wr_cnt, 32'h2);
        $display("edit save done");
    endtask : t_edit_save
    task automatic t_reload();
        resetn_i <= 1'b0;
        repeat (2) @(posedge core_clk_i);
        chk("screen", screen_o, 32'h0);
        resetn_i <= 1'b1;
        repeat (20) @(posedge core_clk_i);
        chk("addr", addr_o, 32'h1F);
        chk("ofs", ref_ofs_o, 32'hC18);
        chk("mute", mute_o, 32'h1);
        chk("lamps", {remote_lamp_o, power_lamp_o, screen_o}, 32'h1A);
        $display("reload done");
    endtask : t_reload
    task automatic t_reply();
        logic [9:0] frame;
        frame = {1'b1, 8'h3E, 1'b0};
        cmd_done_i <= 1'b1;
        @(posedge core_clk_i);
        cmd_done_i <= 1'b0;
        repeat (1302) @(posedge core_clk_i);
        for (int i = 0; i < 10; i++)
        begin
            chk("txd", txd_o, frame[i]);
            repeat (2604) @(posedge core_clk_i);
        end
        $display("reply done");
    endtask : t_reply
    initial
    begin
        resetn_i = 1'b0;
        cmd_done_i = 1'b0;
        pll_unlock_i = 2'h0;
        repeat (12) @(posedge core_clk_i);
        resetn_i <= 1'b1;
        t_power_up();
        t_gain_discard();
        t_remote_save();
        t_idle();
        t_alarm();
        t_edit_save();
        t_reload();
        @(posedge core_clk_i);
        t_reply();
        print_verdict();
    end
    // The serial reply dominates run time, so the limit is sized from its frame.
    initial
    begin
        repeat (40000) @(posedge core_clk_i);
        err_count++;
        print_verdict();
    end
endmodule : testbench
